// >>> logic/sarseq_pkg.sv
// types shared by the conversion sequencer
package sarseq_pkg;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_WAIT, SEQ_SYNC, SEQ_RUN} sarseq_state_e;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } sarseq_apb_rsp_s;

    typedef struct packed {
        logic sample;
        logic [1:0] ref_sel;
        logic [4:0] channel;
        logic gain_bypass;
        logic powered;
        logic trial_bit;
    } sarseq_analog_s;

    typedef struct packed {
        sarseq_state_e state;
        logic en;
        logic sc;
        logic ate;
        logic flag;
        logic [2:0] ps;
        logic [2:0] ts;
        logic [7:0] channel_gain_select;
        logic [1:0] ref_live;
        logic [4:0] ch_live;
        logic [9:0] result;
        logic [9:0] sar;
        logic lock;
        logic first;
        logic [6:0] pre_cnt;
        logic [4:0] cyc;
        logic [4:0] len;
        logic [4:0] sh_at;
        logic [1:0] sync_cnt;
        logic trig_q;
        logic ck2;
        logic was_free;
        sarseq_apb_rsp_s rsp;
        sarseq_analog_s ana;
    } sarseq_state_s;
endpackage

// >>> logic/sarseq_regs.svh
// register offsets, field positions and timing counts of the sequencer
`ifndef SARSEQ_REGS_SVH
`define SARSEQ_REGS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define SARSEQ_OFS_CSRA 12'h000
`define SARSEQ_OFS_CSRB 12'h004
`define SARSEQ_OFS_MUX 12'h008
`define SARSEQ_OFS_RESL 12'h00C
`define SARSEQ_OFS_RESH 12'h010

// ---------------------------------------------------------------
// control status a fields
// ---------------------------------------------------------------
`define SARSEQ_A_EN 7
`define SARSEQ_A_SC 6
`define SARSEQ_A_ATE 5
`define SARSEQ_A_IF 4
`define SARSEQ_A_PS_HI 2

// ---------------------------------------------------------------
// select register fields
// ---------------------------------------------------------------
`define SARSEQ_M_REF_LO 6
`define SARSEQ_M_LAR 5
`define SARSEQ_M_CH_HI 4
`define SARSEQ_CH_DIFF_FIRST 5'h08
`define SARSEQ_CH_DIFF_LAST 5'h1D
`define SARSEQ_TS_FREE 3'h0

// ---------------------------------------------------------------
// conversion timing in conversion clock cycles, trigger sync in cpu cycles
// ---------------------------------------------------------------
`define SARSEQ_CONV_NORMAL 5'h0D
`define SARSEQ_CONV_FIRST 5'h19
`define SARSEQ_CONV_DIFF 5'h0E
`define SARSEQ_SH_NORMAL 5'h01
`define SARSEQ_SH_FIRST 5'h0D
`define SARSEQ_SH_AUTO 5'h02
`define SARSEQ_TRIG_SYNC 2'h3
`define SARSEQ_BITS 4'hA

`endif

// >>> logic/sarseq_top.sv
// conversion sequencer for a 10-bit successive approximation converter, APB slave
//
// Summary of operation
// - ten-bit code by successive approximation
// - differential through gain, single-ended bypasses
// - selections apply only while enabled
// - right aligned, left when select set
// - low byte read blocks result updates
// - high byte read lifts the block
// - complete flag set even when blocked
// - start bit begins, reads one, self-clears
// - channel change waits for running conversion
// - trigger rising edge resets prescaler, starts
// - no restart on level, ignore edges busy
// - complete flag source gives continuous conversions
// - start bit works under auto trigger
// - prescaler divides, held reset while disabled
// - start waits next conversion clock edge
// - normal 13 cycles, first 25
// - sample at 1.5 normal, 13.5 first
// - completion writes result, flag, clears start
// - auto trigger sample two cycles after edge
// - differential auto trigger needs re-enable cycles
// - free running restarts, start bit stays
// - differential high-phase start takes 14 cycles
// - selection held during conversion, tracks last
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "sarseq_regs.svh"

module sarseq_top
    import sarseq_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    input wire logic [7:0] i_trig_src,
    input wire logic i_comp_hi,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_sample,
    output logic [1:0] o_ref_sel,
    output logic [4:0] o_channel,
    output logic o_gain_bypass,
    output logic o_powered,
    output logic o_trial_bit
);

    sarseq_state_s s_reg;
    sarseq_state_s s_next;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // prescaler terminal count, division by 2 to 128
    function automatic logic [6:0] pre_top(input logic [2:0] ps);
        logic [7:0] d;
        d = 8'h01 << ((ps == 3'h0) ? 3'h1 : ps);
        pre_top = 7'(d - 8'h01);
    endfunction

    function automatic logic is_diff(input logic [4:0] ch);
        is_diff = (ch >= `SARSEQ_CH_DIFF_FIRST) && (ch <= `SARSEQ_CH_DIFF_LAST);
    endfunction

    logic acc;
    logic commit;
    logic [9:0] trial_oh;
    logic wr;
    logic rd;
    logic tick;
    logic trig_now;
    logic trig_edge;
    logic start_sw;
    logic done;
    logic [31:0] rdata;
    logic [1:0] ref_mux;
    logic [4:0] ch_mux;

    assign acc = i_psel && i_penable && !s_reg.rsp.pready;
    // writes and read side effects land on the edge that sees pready high
    assign commit = i_psel && i_penable && s_reg.rsp.pready;
    assign wr = commit && i_pwrite && i_pstrb[0];
    assign rd = commit && !i_pwrite;
    // lowest set bit of the register is the bit under trial
    assign trial_oh = s_reg.sar & (~s_reg.sar + 10'h001);
    assign tick = s_reg.en && (s_reg.pre_cnt == pre_top(s_reg.ps));
    assign trig_now = (s_reg.ts == `SARSEQ_TS_FREE) ? s_reg.flag : i_trig_src[s_reg.ts];
    assign trig_edge = trig_now && !s_reg.trig_q;
    assign start_sw = wr && (i_paddr == `SARSEQ_OFS_CSRA) && i_pwdata[`SARSEQ_A_SC];
    assign done = (s_reg.state == SEQ_RUN) && tick && (s_reg.cyc == s_reg.len);
    assign ref_mux = s_reg.channel_gain_select[7:`SARSEQ_M_REF_LO];
    assign ch_mux = s_reg.channel_gain_select[`SARSEQ_M_CH_HI:0];

    // ---------------------------------------------------------------
    // read data mux
    // ---------------------------------------------------------------
    always_comb begin
        rdata = 32'h0000_0000;
        case (i_paddr)
            `SARSEQ_OFS_CSRA: rdata[7:0] = {s_reg.en, s_reg.sc, s_reg.ate, s_reg.flag,
                1'b0, s_reg.ps};
            `SARSEQ_OFS_CSRB: rdata[2:0] = s_reg.ts;
            `SARSEQ_OFS_MUX: rdata[7:0] = s_reg.channel_gain_select;
            `SARSEQ_OFS_RESL: rdata[7:0] = s_reg.channel_gain_select[`SARSEQ_M_LAR] ?
                {s_reg.result[1:0], 6'h00} : s_reg.result[7:0];
            `SARSEQ_OFS_RESH: rdata[7:0] = s_reg.channel_gain_select[`SARSEQ_M_LAR] ?
                s_reg.result[9:2] : {6'h00, s_reg.result[9:8]};
            default: rdata = 32'h0000_0000;
        endcase
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.rsp.pready = acc;
        s_next.rsp.pslverr = 1'b0;
        s_next.ana.sample = 1'b0;
        s_next.trig_q = trig_now;

        // bus side writes and reads
        if (acc) begin
            s_next.rsp.prdata = rdata;
            case (i_paddr)
                `SARSEQ_OFS_CSRA, `SARSEQ_OFS_CSRB, `SARSEQ_OFS_MUX,
                `SARSEQ_OFS_RESL, `SARSEQ_OFS_RESH: s_next.rsp.pslverr = 1'b0;
                default: s_next.rsp.pslverr = 1'b1;
            endcase
        end
        if (wr && i_paddr == `SARSEQ_OFS_CSRA) begin
            s_next.en = i_pwdata[`SARSEQ_A_EN];
            s_next.ate = i_pwdata[`SARSEQ_A_ATE];
            s_next.ps = i_pwdata[`SARSEQ_A_PS_HI:0];
            if (i_pwdata[`SARSEQ_A_IF]) begin
                s_next.flag = 1'b0; // write one clears
            end
            if (start_sw && i_pwdata[`SARSEQ_A_EN]) begin
                s_next.sc = 1'b1;
            end
        end
        if (wr && i_paddr == `SARSEQ_OFS_CSRB) begin
            s_next.ts = i_pwdata[2:0];
        end
        if (wr && i_paddr == `SARSEQ_OFS_MUX) begin
            s_next.channel_gain_select = i_pwdata[7:0];
        end
        if (rd && i_paddr == `SARSEQ_OFS_RESL) begin
            s_next.lock = 1'b1;
        end
        if (rd && i_paddr == `SARSEQ_OFS_RESH) begin
            s_next.lock = 1'b0;
        end

        // prescaler, held in reset while disabled
        if (!s_reg.en || tick) begin
            s_next.pre_cnt = 7'h00;
        end else begin
            s_next.pre_cnt = 7'(s_reg.pre_cnt + 7'h01);
        end
        if (tick) begin
            s_next.ck2 = !s_reg.ck2;
        end
        if (!s_reg.en) begin
            s_next.ck2 = 1'b0;
        end

        // selections track while idle, held during conversion
        if (s_reg.en && (s_reg.state != SEQ_RUN || s_reg.cyc == s_reg.len)) begin
            s_next.ref_live = ref_mux;
            s_next.ch_live = ch_mux;
        end

        case (s_reg.state)
            SEQ_IDLE: begin
                if (s_reg.en && s_reg.ate && trig_edge) begin
                    s_next.state = SEQ_SYNC;
                    s_next.sync_cnt = 2'h0;
                    s_next.pre_cnt = 7'h00;
                    s_next.sc = 1'b1;
                end else if (s_reg.sc) begin
                    s_next.state = SEQ_WAIT;
                end
            end
            SEQ_WAIT: begin
                if (tick) begin
                    s_next.state = SEQ_RUN;
                    s_next.cyc = 5'h01;
                    s_next.sar = 10'h200;
                    s_next.sh_at = s_reg.first ? `SARSEQ_SH_FIRST : `SARSEQ_SH_NORMAL;
                    if (s_reg.first) begin
                        s_next.len = `SARSEQ_CONV_FIRST;
                    end else if (is_diff(s_reg.ch_live) && (s_reg.ck2 || s_reg.was_free)) begin
                        s_next.len = `SARSEQ_CONV_DIFF;
                    end else begin
                        s_next.len = `SARSEQ_CONV_NORMAL;
                    end
                end
            end
            SEQ_SYNC: begin
                // three cpu cycles of trigger synchronisation
                s_next.pre_cnt = 7'h00;
                s_next.sync_cnt = 2'(s_reg.sync_cnt + 2'h1);
                if (s_reg.sync_cnt == 2'(`SARSEQ_TRIG_SYNC - 2'h1)) begin
                    s_next.state = SEQ_RUN;
                    s_next.cyc = 5'h00;
                    s_next.sar = 10'h200;
                    s_next.sh_at = s_reg.first ? `SARSEQ_SH_FIRST : `SARSEQ_SH_AUTO;
                    s_next.len = s_reg.first ? `SARSEQ_CONV_FIRST : `SARSEQ_CONV_NORMAL;
                end
            end
            SEQ_RUN: begin
                if (tick) begin
                    s_next.cyc = 5'(s_reg.cyc + 5'h01);
                    if (s_reg.cyc == s_reg.sh_at) begin
                        s_next.ana.sample = 1'b1;
                    end
                    // one trial bit per cycle after the hold point
                    if (s_reg.cyc > s_reg.sh_at &&
                        s_reg.cyc <= 5'(s_reg.sh_at + 5'(`SARSEQ_BITS))) begin
                        if (i_comp_hi) begin
                            s_next.sar = (s_reg.sar & ~trial_oh) | (trial_oh >> 1);
                        end else begin
                            s_next.sar = s_reg.sar | (trial_oh >> 1);
                        end
                    end
                end
                if (done) begin
                    s_next.first = 1'b0;
                    s_next.flag = 1'b1;
                    if (!s_reg.lock) begin
                        s_next.result = s_reg.sar;
                    end
                    // free running repeats, otherwise idle
                    if (s_reg.ate && s_reg.ts == `SARSEQ_TS_FREE) begin
                        // restart on this very tick, on the freshly tracked selection
                        s_next.state = SEQ_RUN;
                        s_next.cyc = 5'h01;
                        s_next.sar = 10'h200;
                        s_next.sh_at = `SARSEQ_SH_NORMAL;
                        s_next.len = is_diff(ch_mux) ? `SARSEQ_CONV_DIFF :
                            `SARSEQ_CONV_NORMAL;
                        s_next.was_free = 1'b1;
                    end else begin
                        s_next.state = SEQ_IDLE;
                        s_next.sc = 1'b0;
                        s_next.was_free = 1'b0;
                    end
                end
            end
            default: s_next.state = SEQ_IDLE;
        endcase

        // disabling aborts and rearms the long first conversion
        if (!s_reg.en) begin
            s_next.state = SEQ_IDLE;
            s_next.sc = 1'b0;
            s_next.first = 1'b1;
            s_next.was_free = 1'b0;
        end

        s_next.ana.ref_sel = s_reg.ref_live;
        s_next.ana.channel = s_reg.ch_live;
        s_next.ana.gain_bypass = !is_diff(s_reg.ch_live);
        s_next.ana.powered = s_reg.en;
        s_next.ana.trial_bit = (s_reg.state == SEQ_RUN) ? |s_reg.sar : 1'b0;
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s_reg <= '0;
            s_reg.first <= 1'b1;
            s_reg.ana.gain_bypass <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_prdata = s_reg.rsp.prdata;
    assign o_pready = s_reg.rsp.pready;
    assign o_pslverr = s_reg.rsp.pslverr;
    assign o_sample = s_reg.ana.sample;
    assign o_ref_sel = s_reg.ana.ref_sel;
    assign o_channel = s_reg.ana.channel;
    assign o_gain_bypass = s_reg.ana.gain_bypass;
    assign o_powered = s_reg.ana.powered;
    assign o_trial_bit = s_reg.ana.trial_bit;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    property p_done_sets_flag;
        @(posedge i_mclk) disable iff (!i_rst_b) done |=> s_reg.flag;
    endproperty
    a_done_sets_flag: assert property (p_done_sets_flag) else $error("flag not set");

    property p_lock_holds;
        @(posedge i_mclk) disable iff (!i_rst_b) (done && s_reg.lock) |=> $stable(s_reg.result);
    endproperty
    a_lock_holds: assert property (p_lock_holds) else $error("result changed while locked");

    property p_high_unlocks;
        @(posedge i_mclk) disable iff (!i_rst_b)
            (rd && i_paddr == `SARSEQ_OFS_RESH) |=> !s_reg.lock;
    endproperty
    a_high_unlocks: assert property (p_high_unlocks) else $error("lock not lifted");

    property p_sc_busy;
        @(posedge i_mclk) disable iff (!i_rst_b) (s_reg.state == SEQ_RUN) |-> s_reg.sc;
    endproperty
    a_sc_busy: assert property (p_sc_busy) else $error("start bit low while busy");

    property p_single_clears;
        @(posedge i_mclk) disable iff (!i_rst_b) (done && !s_reg.ate) |=> !s_reg.sc;
    endproperty
    a_single_clears: assert property (p_single_clears) else $error("start bit stuck");

    property p_prescaler_reset;
        @(posedge i_mclk) disable iff (!i_rst_b) !s_reg.en |=> s_reg.pre_cnt == 7'h00;
    endproperty
    a_prescaler_reset: assert property (p_prescaler_reset) else $error("prescaler ran");

    property p_chan_held;
        @(posedge i_mclk) disable iff (!i_rst_b)
            (s_reg.state == SEQ_RUN && s_reg.cyc != s_reg.len) |=> $stable(s_reg.ch_live);
    endproperty
    a_chan_held: assert property (p_chan_held) else $error("channel moved");

    property p_power;
        @(posedge i_mclk) disable iff (!i_rst_b) !s_reg.en |=> !o_powered;
    endproperty
    a_power: assert property (p_power) else $error("powered while disabled");

    property p_free_keeps_sc;
        @(posedge i_mclk) disable iff (!i_rst_b)
            (done && s_reg.ate && s_reg.ts == `SARSEQ_TS_FREE && s_reg.en)
            |=> s_reg.sc && s_reg.state == SEQ_RUN;
    endproperty
    a_free_keeps_sc: assert property (p_free_keeps_sc) else $error("free run stopped");

    // bus answer is a single-cycle pulse
    property p_pready_pulse;
        @(posedge i_mclk) disable iff (!i_rst_b) o_pready |=> !o_pready;
    endproperty
    a_pready_pulse: assert property (p_pready_pulse) else $error("pready stuck");

    // trial indicator quiet outside a conversion
    property p_trial_idle;
        @(posedge i_mclk) disable iff (!i_rst_b) (s_reg.state != SEQ_RUN) |=> !o_trial_bit;
    endproperty
    a_trial_idle: assert property (p_trial_idle) else $error("trial bit while idle");

    // differential selection drives the gain stage
    property p_gain_used;
        @(posedge i_mclk) disable iff (!i_rst_b) is_diff(s_reg.ch_live) |=> !o_gain_bypass;
    endproperty
    a_gain_used: assert property (p_gain_used) else $error("gain stage bypassed");

    // main scenarios
    c_done: cover property (@(posedge i_mclk) disable iff (!i_rst_b) done);
    c_free_diff: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
        done && s_reg.was_free && s_reg.len == `SARSEQ_CONV_DIFF);
    c_locked_done: cover property (@(posedge i_mclk) disable iff (!i_rst_b) done && s_reg.lock);
    c_auto: cover property (@(posedge i_mclk) disable iff (!i_rst_b) s_reg.state == SEQ_SYNC);
endmodule
`default_nettype wire

// >>> testbench/sarseq_core_model.sv
// behavioural analog core and trigger source lines facing the sequencer
`timescale 1ns/10ps
`default_nettype none

module sarseq_core_model (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_input_low,
    input wire logic i_fire,
    output logic o_comp_hi,
    output logic [7:0] o_trig_src
);
    // comparator: input held at ground or at full scale
    assign o_comp_hi = i_input_low;

    // trigger source one follows the bench request; software lowers it before re-arming
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_trig_src <= 8'h00;
        end else begin
            o_trig_src <= {6'h00, i_fire, 1'b0};
        end
    end
endmodule

`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking testbench of the conversion sequencer
`timescale 1ns/10ps
`default_nettype none
`include "sarseq_regs.svh"
`define SQ_CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin miscompares++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end

module tb_top;
    import sarseq_pkg::*;
    logic i_mclk, i_rst_b, psel, penable, pwrite, comp_hi, input_low, fire;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic pready, pslverr, smp, pwr, byp, trial, rerr;
    logic [1:0] refs;
    logic [4:0] chan;
    logic [7:0] trig;
    int miscompares = 0, cmp_count = 0, cyc = 0, n_smp = 0, last_smp = 0, gap = 0;

    sarseq_top i_dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hF),
        .i_trig_src(trig), .i_comp_hi(comp_hi), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .o_sample(smp), .o_ref_sel(refs), .o_channel(chan),
        .o_gain_bypass(byp), .o_powered(pwr), .o_trial_bit(trial));
    sarseq_core_model i_core (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_input_low(input_low),
        .i_fire(fire), .o_comp_hi(comp_hi), .o_trig_src(trig));

    // clock, reset and time-zero values
    initial begin
        i_mclk = 0;
        forever #20 i_mclk = ~i_mclk;
    end
    initial begin
        {i_rst_b, psel, penable, pwrite, input_low, fire} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        repeat (3) @(posedge i_mclk);
        i_rst_b <= 1'b1;
    end
    // sample pulse monitor, spacing in clock cycles
    always @(posedge i_mclk) begin
        cyc++;
        if (smp === 1'b1) begin
            gap = cyc - last_smp;
            last_smp = cyc;
            n_smp++;
        end
    end

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge i_mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge i_mclk);
        penable <= 1'b1;
        do begin
            @(posedge i_mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) miscompares++;
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h00000000);
    endtask
    task automatic wait_smp(input int k);
        int n;
        n = 0;
        while (n_smp < k && n < 600) begin
            @(posedge i_mclk);
            n++;
        end
        if (n_smp < k) miscompares++;
    endtask
    // poll until the start bit drops
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            rd(`SARSEQ_OFS_CSRA);
            n++;
        end while (rdata[`SARSEQ_A_SC] !== 1'b0 && n < 100);
        if (rdata[`SARSEQ_A_SC] !== 1'b0) miscompares++;
    endtask
    // clear flag and start one conversion, then wait for it
    task automatic convert();
        wr(`SARSEQ_OFS_CSRA, 32'h000000D0);
        wait_idle();
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        rd(`SARSEQ_OFS_CSRA);
        `SQ_CHK("csra reset", 32'h00000000, rdata)
        `SQ_CHK("bypass reset", 1'b1, byp)
        `SQ_CHK("mapped err", 1'b0, rerr)
        `SQ_CHK("trial idle", 1'b0, trial)
        rd(12'h020);
        `SQ_CHK("unmapped err", 1'b1, rerr)
        `SQ_CHK("unmapped data", 32'h00000000, rdata)
    endtask
    task automatic t_enable();
        wr(`SARSEQ_OFS_MUX, 32'h00000043);
        `SQ_CHK("channel off", 5'h00, chan)
        `SQ_CHK("powered off", 1'b0, pwr)
        wr(`SARSEQ_OFS_CSRA, 32'h00000080);
        repeat (4) @(posedge i_mclk);
        `SQ_CHK("powered on", 1'b1, pwr)
        `SQ_CHK("channel on", 5'h03, chan)
        `SQ_CHK("ref on", 2'h1, refs)
        `SQ_CHK("bypass single", 1'b1, byp)
    endtask
    task automatic t_free();
        wr(`SARSEQ_OFS_CSRB, 32'h00000000);
        wr(`SARSEQ_OFS_CSRA, 32'h000000E0);
        wait_smp(n_smp + 3);
        `SQ_CHK("free gap", 26, gap)
        rd(`SARSEQ_OFS_CSRA);
        `SQ_CHK("free start bit", 1'b1, rdata[`SARSEQ_A_SC])
        wait_smp(n_smp + 1);
        wr(`SARSEQ_OFS_MUX, 32'h00000048);
        `SQ_CHK("channel held", 5'h03, chan)
        wait_smp(n_smp + 4);
        `SQ_CHK("diff gap", 28, gap)
        `SQ_CHK("channel diff", 5'h08, chan)
        `SQ_CHK("bypass diff", 1'b0, byp)
        wr(`SARSEQ_OFS_CSRA, 32'h00000080);
        wait_idle();
    endtask
    task automatic t_single();
        int s0;
        wr(`SARSEQ_OFS_MUX, 32'h00000003);
        wr(`SARSEQ_OFS_CSRA, 32'h00000090);
        s0 = n_smp;
        wr(`SARSEQ_OFS_CSRA, 32'h000000C0);
        rd(`SARSEQ_OFS_CSRA);
        `SQ_CHK("start busy", 1'b1, rdata[`SARSEQ_A_SC])
        wait_idle();
        `SQ_CHK("flag done", 1'b1, rdata[`SARSEQ_A_IF])
        `SQ_CHK("one sample", s0 + 1, n_smp)
        rd(`SARSEQ_OFS_RESL);
        `SQ_CHK("low right", 32'h000000FF, rdata)
        rd(`SARSEQ_OFS_RESH);
        `SQ_CHK("high right", 32'h00000003, rdata)
    endtask
    task automatic t_lock();
        rd(`SARSEQ_OFS_RESL);
        input_low <= 1'b1;
        convert();
        `SQ_CHK("flag locked", 1'b1, rdata[`SARSEQ_A_IF])
        rd(`SARSEQ_OFS_RESH);
        `SQ_CHK("high locked", 32'h00000003, rdata)
        convert();
        rd(`SARSEQ_OFS_RESL);
        `SQ_CHK("low unlocked", 32'h00000000, rdata)
        rd(`SARSEQ_OFS_RESH);
        `SQ_CHK("high unlocked", 32'h00000000, rdata)
        input_low <= 1'b0;
        wr(`SARSEQ_OFS_MUX, 32'h00000023);
        convert();
        rd(`SARSEQ_OFS_RESL);
        `SQ_CHK("low left", 32'h000000C0, rdata)
        rd(`SARSEQ_OFS_RESH);
        `SQ_CHK("high left", 32'h000000FF, rdata)
    endtask
    task automatic t_auto();
        int s0;
        wr(`SARSEQ_OFS_CSRB, 32'h00000001);
        wr(`SARSEQ_OFS_CSRA, 32'h000000B0);
        s0 = n_smp;
        @(posedge i_mclk);
        fire <= 1'b1;
        repeat (10) @(posedge i_mclk);
        fire <= 1'b0;
        repeat (2) @(posedge i_mclk);
        fire <= 1'b1;
        repeat (30) @(posedge i_mclk);
        `SQ_CHK("trigger sample", s0 + 1, n_smp)
        repeat (100) @(posedge i_mclk);
        `SQ_CHK("no level restart", s0 + 1, n_smp)
        fire <= 1'b0;
        wr(`SARSEQ_OFS_CSRA, 32'h00000000);
        repeat (2) @(posedge i_mclk);
        `SQ_CHK("powered down", 1'b0, pwr)
    endtask

    task automatic report_and_stop();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        wait (i_rst_b === 1'b1);
        t_reset();
        t_enable();
        t_free();
        t_single();
        t_lock();
        t_auto();
        report_and_stop();
    end
    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge i_mclk);
        miscompares++;
        report_and_stop();
    end
endmodule

`default_nettype wire
